//--- src/pwm_st_pkg.sv
package pwm_st_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_CLOCK_DIV = 4'h1;
	localparam logic [3:0] ADDR_TRIGGER = 4'h2;
	localparam logic [3:0] ADDR_PERIOD = 4'h3;
	localparam logic [3:0] ADDR_ENABLE = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h6;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h7;
	localparam logic [3:0] ADDR_EVENT_CMP = 4'h8;

	// ----------------------------------------
	// Control and trigger field positions
	// ----------------------------------------
	localparam int POS_PENDING = 12;
	localparam int POS_IRQ_EN = 11;
	localparam int POS_IMMEDIATE = 10;
	localparam int POS_POLARITY = 9;
	localparam int POS_SYNC_OEN = 8;
	localparam int POS_EXT_SYNC = 7;
	localparam int POS_SRC_LO = 4;
	localparam int POS_PS_LO = 0;
	localparam int POS_TRG_DIV_LO = 12;
	localparam int POS_TRG_START_LO = 0;

	localparam logic [15:0] RESET_CONTROL = 16'h0000;
	localparam logic [2:0] RESET_CLOCK_DIV = 3'h0;
	localparam logic [15:0] RESET_PERIOD = 16'hFFFF;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [2:0] SRC_SYNC_IN_ONE = 3'h0;
	localparam logic [2:0] SRC_TRIG_GEN_16 = 3'h2;
	localparam logic [2:0] SRC_TRIG_GEN_17 = 3'h3;
	localparam logic [2:0] CLKDIV_MAX = 3'h6;

	// Status bit layout of the interrupt registers
	localparam int IRQ_BITS = 3;
	localparam int IRQ_SPECIAL = 0;
	localparam int IRQ_TRIGGER = 1;
	localparam int IRQ_SYNC = 2;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic sync_input_one;
		logic sync_input_two;
		logic trigger_gen_output_16;
		logic trigger_gen_output_17;
	} sync_in_t;

endpackage

//--- src/pwm_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_prescaler (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_run,
	input wire logic [2:0] i_input_clock_divider,
	output logic o_tick
);
	import pwm_st_pkg::*;

	typedef struct packed {
		logic [5:0] count;
		logic tick;
	} presc_state_t;

	presc_state_t state;
	presc_state_t next_state;
	logic [5:0] limit;

	always_comb begin
		// Reserved code falls back to the slowest legal divide
		if (i_input_clock_divider > CLKDIV_MAX) begin
			limit = 6'h3F;
		end else begin
			limit = 6'((7'h01 << i_input_clock_divider) - 7'h01);
		end
		next_state = state;
		next_state.tick = 1'b0;
		if (!i_run) begin
			next_state.count = 6'h00;
		end else if (state.count >= limit) begin
			next_state.count = 6'h00;
			next_state.tick = 1'b1;
		end else begin
			next_state.count = state.count + 6'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_tick = state.tick;

endmodule

`default_nettype wire

//--- src/pwm_secondary_timebase_trigger_ctrl.sv
// Function
// - Pending status bit set by hardware, cleared by hardware or by an IRQ clear write, read-only.
// - Special event interrupt raised only while its enable bit is one.
// - Immediate update loads active period on write, else at cycle boundary; a write while the time base is off loads it at once.
// - Polarity bit one makes sync input and output active-low.
// - Sync output driven only while sync output enable is one.
// - External sync source restarts time base only while enabled.
// - Source 000 sync input one, 010 trigger-gen 16, 011 trigger-gen 17.
// - Prescaler divides by two to the code, up to 64; 111 reserved.
`timescale 1ns/1ps
`default_nettype none

module pwm_secondary_timebase_trigger_ctrl (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire pwm_st_pkg::reg_req_t i_req,
	input wire pwm_st_pkg::sync_in_t i_sync,
	output logic [15:0] o_rdata,
	output logic o_sync_output_two,
	output logic o_sync_output_two_oe,
	output logic o_trigger,
	output logic o_special_event,
	output logic o_irq
);
	import pwm_st_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] control;
		logic [2:0] input_clock_divider;
		logic [3:0] trigger_output_divider;
		logic [5:0] trigger_start_delay;
		logic [15:0] period_buffer;
		logic [15:0] period_active;
		logic [15:0] event_compare;
		logic timebase_enable;
		logic [15:0] counter;
		logic [5:0] start_count;
		logic [3:0] trig_count;
		logic [IRQ_BITS-1:0] irq_status;
		logic [IRQ_BITS-1:0] irq_enable;
		logic [3:0] sync_meta;
		logic [3:0] sync_sync;
		logic sync_prev;
		logic sync_out;
		logic sync_oe;
		logic trigger;
		logic special_event;
		logic irq;
		logic [15:0] rdata;
	} ctrl_state_t;

	ctrl_state_t state;
	ctrl_state_t next_state;
	logic tick;
	logic sel_sync;
	logic sync_active;
	logic sync_edge;
	logic boundary;
	logic event_hit;
	logic [IRQ_BITS-1:0] irq_set;
	logic [2:0] src;

	pwm_prescaler u_prescaler (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_run(state.timebase_enable),
		.i_input_clock_divider(state.input_clock_divider),
		.o_tick(tick)
	);

	function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
		hit = (addr == target);
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_state = state;
		src = state.control[POS_SRC_LO +: 3];
		next_state.trigger = 1'b0;
		next_state.special_event = 1'b0;
		irq_set = '0;

		// Pins pass two flops before anything looks at them
		next_state.sync_meta = i_sync;
		next_state.sync_sync = state.sync_meta;

		case (src)
			SRC_SYNC_IN_ONE: sel_sync = state.sync_sync[3];
			SRC_TRIG_GEN_16: sel_sync = state.sync_sync[1];
			SRC_TRIG_GEN_17: sel_sync = state.sync_sync[0];
			default: sel_sync = 1'b0;
		endcase
		sync_active = sel_sync ^ state.control[POS_POLARITY];
		next_state.sync_prev = sync_active;
		sync_edge = sync_active && !state.sync_prev && state.control[POS_EXT_SYNC];

		// Time base counting on prescaled ticks
		boundary = 1'b0;
		event_hit = 1'b0;
		if (!state.timebase_enable) begin
			next_state.counter = 16'h0000;
			next_state.start_count = 6'h00;
			next_state.trig_count = 4'h0;
		end else if (sync_edge) begin
			next_state.counter = 16'h0000;
			irq_set[IRQ_SYNC] = 1'b1;
		end else if (tick) begin
			event_hit = (state.counter == state.event_compare);
			if (state.counter >= state.period_active) begin
				next_state.counter = 16'h0000;
				boundary = 1'b1;
			end else begin
				next_state.counter = state.counter + 16'h0001;
			end
		end

		if (boundary && !state.control[POS_IMMEDIATE]) begin
			next_state.period_active = state.period_buffer;
		end

		// Trigger start delay counted in PWM cycles, then divider
		if (boundary && state.start_count < state.trigger_start_delay) begin
			next_state.start_count = state.start_count + 6'h01;
		end else if (event_hit && state.start_count >= state.trigger_start_delay) begin
			if (state.trig_count >= state.trigger_output_divider) begin
				next_state.trig_count = 4'h0;
				next_state.trigger = 1'b1;
				irq_set[IRQ_TRIGGER] = 1'b1;
			end else begin
				next_state.trig_count = state.trig_count + 4'h1;
			end
		end

		// Special event sets pending while its enable bit is one
		if (event_hit && state.control[POS_IRQ_EN]) begin
			next_state.control[POS_PENDING] = 1'b1;
			next_state.special_event = 1'b1;
			irq_set[IRQ_SPECIAL] = 1'b1;
		end

		// Sync output mirrors the period boundary
		next_state.sync_oe = state.control[POS_SYNC_OEN];
		next_state.sync_out = state.control[POS_SYNC_OEN]
			& (boundary ^ state.control[POS_POLARITY]);

		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		if (i_req.wr) begin
			if (hit(i_req.addr, ADDR_CONTROL)) begin
				next_state.control[11:0] = i_req.wdata[11:0];
			end
			if (hit(i_req.addr, ADDR_CLOCK_DIV)) begin
				next_state.input_clock_divider = i_req.wdata[2:0];
			end
			if (hit(i_req.addr, ADDR_TRIGGER)) begin
				next_state.trigger_output_divider = i_req.wdata[POS_TRG_DIV_LO +: 4];
				next_state.trigger_start_delay = i_req.wdata[POS_TRG_START_LO +: 6];
			end
			if (hit(i_req.addr, ADDR_PERIOD)) begin
				next_state.period_buffer = i_req.wdata;
				if (state.control[POS_IMMEDIATE] || !state.timebase_enable) begin
					next_state.period_active = i_req.wdata;
				end
			end
			if (hit(i_req.addr, ADDR_ENABLE)) begin
				next_state.timebase_enable = i_req.wdata[0];
			end
			if (hit(i_req.addr, ADDR_IRQ_ENABLE)) begin
				next_state.irq_enable = i_req.wdata[IRQ_BITS-1:0];
			end
			if (hit(i_req.addr, ADDR_EVENT_CMP)) begin
				next_state.event_compare = i_req.wdata;
			end
			if (hit(i_req.addr, ADDR_IRQ_CLEAR)) begin
				next_state.irq_status = state.irq_status & ~i_req.wdata[IRQ_BITS-1:0];
				// Acknowledging the special event retires the pending bit
				if (i_req.wdata[IRQ_SPECIAL]) begin
					next_state.control[POS_PENDING] = 1'b0;
				end
			end
		end
		// Set wins over a same-cycle clear
		next_state.irq_status = next_state.irq_status | irq_set;
		if (irq_set[IRQ_SPECIAL]) begin
			next_state.control[POS_PENDING] = 1'b1;
		end
		if (!state.control[POS_IRQ_EN]) begin
			next_state.control[POS_PENDING] = 1'b0;
		end
		next_state.irq = |(next_state.irq_status & next_state.irq_enable);

		// ----------------------------------------
		// Register reads, data in the next cycle
		// ----------------------------------------
		next_state.rdata = 16'h0000;
		if (i_req.rd) begin
			case (i_req.addr)
				ADDR_CONTROL: next_state.rdata = {3'h0, state.control[12:0]};
				ADDR_CLOCK_DIV: next_state.rdata = {13'h0000, state.input_clock_divider};
				ADDR_TRIGGER: next_state.rdata = {state.trigger_output_divider, 6'h00,
					state.trigger_start_delay};
				ADDR_PERIOD: next_state.rdata = state.period_buffer;
				ADDR_ENABLE: next_state.rdata = {15'h0000, state.timebase_enable};
				ADDR_IRQ_STATUS: next_state.rdata = {13'h0000, state.irq_status};
				ADDR_IRQ_ENABLE: next_state.rdata = {13'h0000, state.irq_enable};
				ADDR_EVENT_CMP: next_state.rdata = state.event_compare;
				default: next_state.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= '0;
			state.control <= RESET_CONTROL;
			state.input_clock_divider <= RESET_CLOCK_DIV;
			state.period_buffer <= RESET_PERIOD;
			state.period_active <= RESET_PERIOD;
		end else begin
			state <= next_state;
		end
	end

	assign o_rdata = state.rdata;
	assign o_sync_output_two = state.sync_out;
	assign o_sync_output_two_oe = state.sync_oe;
	assign o_trigger = state.trigger;
	assign o_special_event = state.special_event;
	assign o_irq = state.irq;

endmodule

`default_nettype wire

//--- tb/pwm_st_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_st_monitor (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire pwm_st_pkg::reg_req_t i_req,
	input wire pwm_st_pkg::sync_in_t i_sync,
	input wire logic [15:0] o_rdata,
	input wire logic o_sync_output_two,
	input wire logic o_sync_output_two_oe,
	input wire logic o_trigger,
	input wire logic o_special_event,
	input wire logic o_irq
);
	import pwm_st_pkg::*;
	logic [15:0] ctl;
	logic [2:0] div;
	logic [2:0] ien;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ctl <= 16'h0000;
			div <= 3'h0;
			ien <= 3'h0;
		end else if (i_req.wr) begin
			if (i_req.addr == ADDR_CONTROL) ctl <= i_req.wdata;
			if (i_req.addr == ADDR_CLOCK_DIV) div <= i_req.wdata[2:0];
			if (i_req.addr == ADDR_IRQ_ENABLE) ien <= i_req.wdata[2:0];
		end
	end
	// ----
	// Assertions
	// ----
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_rd(logic [3:0] a);
		$past(i_req.rd) && $past(i_req.addr) == a;
	endsequence
	property p_div; s_rd(ADDR_CLOCK_DIV) |-> o_rdata == {13'h0000, $past(div)}; endproperty
	a_div: assert property (p_div)
		else $error("divider readback");
	property p_ctl;
		s_rd(ADDR_CONTROL) |-> o_rdata[15:13] == 3'h0 && o_rdata[11:0] == $past(ctl[11:0]);
	endproperty
	a_ctl: assert property (p_ctl)
		else $error("control readback");
	property p_pend;
		s_rd(ADDR_CONTROL) ##0 (!$past(ctl[11]) && !$past(ctl[11], 2)) |-> !o_rdata[12];
	endproperty
	a_pend: assert property (p_pend)
		else $error("pending with event off");
	property p_oe_off; !o_sync_output_two_oe |-> !o_sync_output_two; endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("sync out while off");
	property p_oe;
		$past(ctl[8]) == ctl[8] && $past(ctl[8], 2) == ctl[8]
			|-> o_sync_output_two_oe == ctl[8];
	endproperty
	a_oe: assert property (p_oe)
		else $error("sync enable mismatch");
	property p_irq; ien == 3'h0 && $past(ien) == 3'h0 && $past(ien, 2) == 3'h0 |-> !o_irq; endproperty
	a_irq: assert property (p_irq)
		else $error("irq while masked");
	property p_sev; o_special_event |-> ctl[11] || $past(ctl[11]); endproperty
	a_sev: assert property (p_sev)
		else $error("event while disabled");
	property p_lvl;
		o_sync_output_two_oe && $stable(ctl[9]) && $past(ctl[9], 2) == ctl[9]
			&& o_sync_output_two != ctl[9] |=> o_sync_output_two == ctl[9];
	endproperty
	a_lvl: assert property (p_lvl)
		else $error("sync idle level");
endmodule
bind pwm_secondary_timebase_trigger_ctrl pwm_st_monitor mon (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_req(i_req), .i_sync(i_sync), .o_rdata(o_rdata), .o_sync_output_two(o_sync_output_two),
	.o_sync_output_two_oe(o_sync_output_two_oe), .o_trigger(o_trigger),
	.o_special_event(o_special_event), .o_irq(o_irq));
`default_nettype wire

//--- tb/sync_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sync_partner (
	input wire logic i_clk,
	input wire logic i_pol_low,
	input wire logic [3:0] i_fire,
	output wire pwm_st_pkg::sync_in_t o_sync
);
	import pwm_st_pkg::*;
	// Held several cycles so the two-flop resync cannot miss it
	logic [3:0] act = 4'h0;
	logic [2:0] left = 3'h0;
	always @(posedge i_clk) begin
		if (i_fire != 4'h0) begin
			act <= i_fire;
			left <= 3'h4;
		end else if (left != 3'h0) begin
			left <= left - 3'h1;
		end else begin
			act <= 4'h0;
		end
	end
	assign o_sync = sync_in_t'(act ^ {4{i_pol_low}});
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pwm_st_pkg::*;
	// Address, value before write, write data, readback
	localparam logic [51:0] ROWS [9] = '{52'h0_0000_FFFF_0FFF, 52'h0_0FFF_0000_0000,
		52'h1_0000_FFFF_0007, 52'h2_0000_FFFF_F03F, 52'h3_FFFF_0003_0003,
		52'h6_0000_FFFF_0007, 52'h7_0000_0007_0000, 52'h5_0000_FFFF_0000,
		52'hF_0000_1234_0000};
	// Control, pins pulsed, expected sync status
	localparam logic [23:0] SYNC [7] = '{24'h008084, 24'h000080, 24'h00A024,
		24'h00B014, 24'h00A080, 24'h009080, 24'h038084};
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	reg_req_t req = '0;
	logic pol = 1'b0;
	logic [3:0] fire = 4'h0;
	sync_in_t sync;
	logic [15:0] rdata;
	logic sout;
	logic soe;
	logic trg;
	logic irq;
	logic sev;
	int nev = 0;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	int ns = 0;
	int t;
	int lat [2];
	logic [15:0] v;
	pwm_secondary_timebase_trigger_ctrl uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req),
		.i_sync(sync), .o_rdata(rdata), .o_sync_output_two(sout),
		.o_sync_output_two_oe(soe), .o_trigger(trg), .o_special_event(sev), .o_irq(irq));
	sync_partner far_end (.i_clk(i_clk), .i_pol_low(pol), .i_fire(fire), .o_sync(sync));
	always #2 i_clk = ~i_clk;
	always @(posedge sout) ns++;
	always @(posedge sev) nev++;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clk);
		req.wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge i_clk);
		req.rd <= 1'b0;
		// Data stands only in the cycle after the strobe
		@(posedge i_clk);
		d = rdata;
	endtask
	task automatic wait_trg(output int n);
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (trg !== 1'b1);
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		for (int p = 0; p < 2; p++) begin
			i_rst_b <= 1'b0;
			repeat (3) @(posedge i_clk);
			i_rst_b <= 1'b1;
			@(posedge i_clk);
			chk(16'({trg, sev, irq, soe, sout}), 16'h0000);
			foreach (ROWS[i]) begin
				rd(ROWS[i][51:48], v);
				chk(v, ROWS[i][47:32]);
				wr(ROWS[i][51:48], ROWS[i][31:16]);
				rd(ROWS[i][51:48], v);
				chk(v, ROWS[i][15:0]);
			end
		end
		wr(ADDR_EVENT_CMP, 16'h0001);
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_ENABLE, 16'h0000);
			wr(ADDR_CLOCK_DIV, 16'(k));
			wr(ADDR_TRIGGER, 16'(k % 4) << 12);
			wr(ADDR_ENABLE, 16'h0001);
			wait_trg(t);
			wait_trg(t);
			chk(16'(t), 16'((k % 4 + 1) * 4 << (k > 6 ? 6 : k)));
		end
		wr(ADDR_CLOCK_DIV, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_ENABLE, 16'h0000);
			wr(ADDR_TRIGGER, 16'(i * 63));
			wr(ADDR_ENABLE, 16'h0001);
			wait_trg(lat[i]);
		end
		chk(16'(lat[1] - lat[0]), 16'h00FC);
		wr(ADDR_IRQ_ENABLE, 16'h0001);
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CONTROL, 16'(s) << 11);
			wr(ADDR_IRQ_CLEAR, 16'h0007);
			t = nev;
			repeat (20) @(posedge i_clk);
			rd(ADDR_IRQ_STATUS, v);
			chk(v & 16'h0001, 16'(s));
			chk(16'(irq), 16'(s));
			chk(16'(nev - t > 2), 16'(s));
			rd(ADDR_CONTROL, v);
			chk(16'(v[12]), 16'(s));
		end
		wr(ADDR_ENABLE, 16'h0000);
		wr(ADDR_IRQ_CLEAR, 16'h0001);
		rd(ADDR_CONTROL, v);
		chk(v, 16'h0800);
		chk(16'(irq), 16'h0000);
		wr(ADDR_PERIOD, 16'hFFFF);
		foreach (SYNC[i]) begin
			wr(ADDR_ENABLE, 16'h0000);
			wr(ADDR_CONTROL, SYNC[i][23:8]);
			pol <= SYNC[i][17];
			wr(ADDR_ENABLE, 16'h0001);
			repeat (4) @(posedge i_clk);
			wr(ADDR_IRQ_CLEAR, 16'h0007);
			fire <= SYNC[i][7:4];
			@(posedge i_clk);
			fire <= 4'h0;
			repeat (6) @(posedge i_clk);
			rd(ADDR_IRQ_STATUS, v);
			chk(v & 16'h0004, 16'(SYNC[i][3:0]));
		end
		chk(16'({soe, sout}), 16'h0003);
		for (int m = 0; m < 2; m++) begin
			wr(ADDR_ENABLE, 16'h0000);
			wr(ADDR_PERIOD, 16'hFFFF);
			wr(ADDR_CONTROL, 16'(m) << 10 | 16'h0100);
			pol <= 1'b0;
			wr(ADDR_ENABLE, 16'h0001);
			wr(ADDR_PERIOD, 16'h0003);
			t = ns;
			repeat (100) @(posedge i_clk);
			chk(16'(ns - t > 20), 16'(m));
		end
		summarize();
	end
endmodule
`default_nettype wire
